// >>> hdl/tsa_pkg.sv
// Shared constants for the touch converter control ends
package tsa_pkg;
	localparam logic [6:0] REG_ADC     = 7'h00;
	localparam logic [6:0] REG_CTRL2   = 7'h01;
	localparam logic [6:0] REG_REF     = 7'h03;
	localparam logic [6:0] REG_CFG     = 7'h05;
	localparam logic [6:0] REG_CLKSEL  = 7'h46;
	localparam logic [6:0] REG_RES0    = 7'h08;
	localparam int         NCH         = 6;
	localparam int         CH_X        = 0;
	localparam int         CH_Y        = 1;
	localparam int         CH_Z1       = 2;
	localparam int         CH_Z2       = 3;
	localparam int         CH_BAT      = 4;
	localparam int         CH_AUX      = 5;
	localparam int         SCAN_LSB    = 10;
	localparam int         RES_LSB     = 8;
	localparam int         DIV_LSB     = 4;
	localparam int         PMODE_LSB   = 14;
	localparam int         HOSTCTL_BIT = 12;
	localparam int         CLK17_BIT   = 13;
	localparam int         REF_LVL_BIT = 0;
	localparam int         REF_OFF_BIT = 1;
	localparam int         PRE_LSB     = 3;
	localparam int         SENSE_LSB   = 0;
	localparam logic [3:0] SCAN_NONE   = 4'h0;
	localparam logic [3:0] SCAN_XY     = 4'h1;
	localparam logic [3:0] SCAN_XYZ    = 4'h2;
	localparam logic [3:0] SCAN_X      = 4'h3;
	localparam logic [3:0] SCAN_Y      = 4'h4;
	localparam logic [3:0] SCAN_Z      = 4'h5;
	localparam logic [3:0] SCAN_BAT    = 4'h6;
	localparam logic [3:0] SCAN_AUX    = 4'h7;
	localparam logic [1:0] RES_12      = 2'h0;
	localparam logic [1:0] RES_8       = 2'h1;
	localparam logic [1:0] RES_10      = 2'h2;
	localparam logic [1:0] PM_PEN      = 2'h0;
	localparam logic [1:0] PM_DAV      = 2'h1;
	localparam int         NUM_13      = 13;
	localparam int         NUM_17      = 17;
	localparam int         DEN_PLL_13  = 160;
	localparam int         DEN_PLL_17  = 192;
	localparam int         DEN_Q_13    = 10;
	localparam int         DEN_Q_17    = 12;
	localparam int         REF_CLK_HZ  = 200_000_000;
	localparam int         OSC_HZ      = 8_000_000;
	localparam int         OSC_DIV     = REF_CLK_HZ / OSC_HZ;
	localparam int         FRAME_BITS  = 32;
	localparam int         HDR_BITS    = 16;
	localparam int         RNW_BIT     = 15;
	localparam int         ADDR_LSB    = 7;
	localparam logic [15:0] RST_ADC    = 16'h0000;
	localparam logic [15:0] RST_CTRL2  = 16'h0000;
	localparam logic [15:0] RST_REF    = 16'h0000;
	localparam logic [15:0] RST_CFG    = 16'h0000;
	localparam logic [15:0] RST_CLKSEL = 16'h0000;
endpackage : tsa_pkg

// >>> hdl/tsa_if.sv
// Pin carrier between the touch converter and its host
`timescale 1ns/1ps
interface tsa_if;
	logic sclk;
	logic cs_n;
	logic mosi;
	logic miso_o;
	logic miso_oe;
	logic miso_w;
	logic touch_or_result_ready_n;
	// Undriven data line floats high
	assign miso_w = miso_oe ? miso_o : 1'b1;
	modport dev (input sclk, input cs_n, input mosi, output miso_o, output miso_oe,
		output touch_or_result_ready_n);
	modport host (output sclk, output cs_n, output mosi, input miso_w, input touch_or_result_ready_n);
endinterface : tsa_if

// >>> hdl/tsa_dev.sv
// Touch converter control: registers, clocking, sequencing, pen/data-ready pin
`timescale 1ns/1ps
module tsa_dev #(
	parameter int STAB_TICKS = 4
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	// Host link
	tsa_if.dev               link,
	// Panel and converter analog side
	input  wire logic        xp_level,
	input  wire logic        hw_pd,
	input  wire logic        adc_above,
	output logic             ydrv_gnd,
	output logic             xp_pullup_en,
	output logic             precharge_en,
	output logic [2:0]       drv_sel,
	output logic             sar_sample,
	output logic [11:0]      sar_code,
	output logic             ratiometric,
	output logic             int_ref_on,
	output logic             ref_2v5,
	// Audio clocking
	input  wire logic        audio_on,
	input  wire logic        mclk_tick,
	input  wire logic        pll_en,
	input  wire logic [5:0]  pll_k,
	input  wire logic [2:0]  pll_p,
	input  wire logic [3:0]  q_div,
	output logic             osc_pd
);
	localparam int NCH = tsa_pkg::NCH;

	typedef enum logic [2:0] {ST_IDLE, ST_PRE, ST_SENSE, ST_SETTLE, ST_CONV} tsa_state_t;

	function automatic logic [NCH-1:0] set_mask(input logic [3:0] scan);
		case (scan)
			tsa_pkg::SCAN_XY:  set_mask = 6'b000011;
			tsa_pkg::SCAN_XYZ: set_mask = 6'b001111;
			tsa_pkg::SCAN_X:   set_mask = 6'b000001;
			tsa_pkg::SCAN_Y:   set_mask = 6'b000010;
			tsa_pkg::SCAN_Z:   set_mask = 6'b001100;
			tsa_pkg::SCAN_BAT: set_mask = 6'b010000;
			tsa_pkg::SCAN_AUX: set_mask = 6'b100000;
			default:           set_mask = 6'b000000;
		endcase
	endfunction : set_mask

	function automatic logic [3:0] res_top(input logic [1:0] res);
		case (res)
			tsa_pkg::RES_8:  res_top = 4'h7;
			tsa_pkg::RES_10: res_top = 4'h9;
			default:         res_top = 4'hb;
		endcase
	endfunction : res_top

	logic [15:0]    adc_q, ctrl2_q, ref_q, cfg_q, clksel_q;
	logic [11:0]    res_q [NCH];
	logic [NCH-1:0] unread_q;
	tsa_state_t     st_q;
	logic [2:0]     ch_q;
	logic [3:0]     bit_q, cnt_q;
	logic           dav_q, pen_latch_q, pen_n_q;

	// Serial slave: 16-bit header then 16 data bits
	logic        sclk_q;
	logic [5:0]  bits_q;
	logic [15:0] sh_q, rd_q;
	logic        rise, hdr_done, wr_done, hdr_q;
	logic [6:0]  addr, addr_q;
	logic [15:0] hdr_word;
	assign rise     = link.sclk & ~sclk_q;
	assign hdr_word = {sh_q[14:0], link.mosi};
	assign hdr_done = rise & (bits_q == 6'(tsa_pkg::HDR_BITS - 1));
	// Read frames write nothing; address held past the header
	assign wr_done  = rise & (bits_q == 6'(tsa_pkg::FRAME_BITS - 1)) & ~link.cs_n & ~hdr_q;
	assign addr     = hdr_done ? hdr_word[tsa_pkg::ADDR_LSB +: 7] : addr_q;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sclk_q <= 1'b0;
			bits_q <= 6'h00;
			sh_q   <= 16'h0000;
		end else begin
			sclk_q <= link.sclk;
			if (link.cs_n) begin
				bits_q <= 6'h00;
			end else if (rise) begin
				bits_q <= bits_q + 6'h01;
				sh_q   <= {sh_q[14:0], link.mosi};
			end
		end
	end

	logic rd_hit;
	logic [15:0] rd_data;
	always_comb begin
		rd_data = 16'h0000;
		rd_hit  = 1'b0;
		if (addr == tsa_pkg::REG_ADC) begin
			rd_data = adc_q;
		end else if (addr == tsa_pkg::REG_CTRL2) begin
			rd_data = {ctrl2_q[15:1], dav_q};
		end else if (addr == tsa_pkg::REG_REF) begin
			rd_data = ref_q;
		end else if (addr == tsa_pkg::REG_CFG) begin
			rd_data = cfg_q;
		end else if (addr == tsa_pkg::REG_CLKSEL) begin
			rd_data = clksel_q;
		end else if (addr >= tsa_pkg::REG_RES0 && addr < tsa_pkg::REG_RES0 + 7'(NCH)) begin
			rd_data = {4'h0, res_q[3'(addr - tsa_pkg::REG_RES0)]};
			rd_hit  = 1'b1;
		end
	end

	// Read data leaves MSB first; host samples before each shift
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rd_q   <= 16'h0000;
			hdr_q  <= 1'b0;
			addr_q <= 7'h00;
		end else if (hdr_done) begin
			rd_q   <= rd_data;
			hdr_q  <= hdr_word[tsa_pkg::RNW_BIT];
			addr_q <= hdr_word[tsa_pkg::ADDR_LSB +: 7];
		end else if (rise) begin
			rd_q <= {rd_q[14:0], 1'b0};
		end else if (link.cs_n) begin
			hdr_q <= 1'b0;
		end
	end
	assign link.miso_o  = rd_q[15];
	assign link.miso_oe = ~link.cs_n & hdr_q;

	logic wr_adc, wr_adc_q;
	assign wr_adc = wr_done & (addr == tsa_pkg::REG_ADC);
	// Start a cycle late so the new scan field is decoded
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wr_adc_q <= 1'b0;
		end else begin
			wr_adc_q <= wr_adc;
		end
	end
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			adc_q    <= tsa_pkg::RST_ADC;
			ctrl2_q  <= tsa_pkg::RST_CTRL2;
			ref_q    <= tsa_pkg::RST_REF;
			cfg_q    <= tsa_pkg::RST_CFG;
			clksel_q <= tsa_pkg::RST_CLKSEL;
		end else if (wr_done) begin
			if (addr == tsa_pkg::REG_ADC) adc_q <= {sh_q[14:0], link.mosi};
			if (addr == tsa_pkg::REG_CTRL2) ctrl2_q <= {sh_q[14:0], link.mosi};
			if (addr == tsa_pkg::REG_REF) ref_q <= {sh_q[14:0], link.mosi};
			if (addr == tsa_pkg::REG_CFG) cfg_q <= {sh_q[14:0], link.mosi};
			if (addr == tsa_pkg::REG_CLKSEL) clksel_q <= {sh_q[14:0], link.mosi};
		end
	end

	assign ref_2v5    = ref_q[tsa_pkg::REF_LVL_BIT];
	assign int_ref_on = ~ref_q[tsa_pkg::REF_OFF_BIT];
	assign ratiometric = (st_q != ST_IDLE) && (ch_q < 3'(tsa_pkg::CH_BAT));

	// Base 8 MHz tick: oscillator or master-clock ratio
	logic [4:0]  osc_q;
	logic [15:0] acc_q;
	logic [15:0] num, den;
	logic        base_tick, nco_tick;
	assign osc_pd = audio_on;
	always_comb begin
		if (pll_en) begin
			num = clksel_q[tsa_pkg::CLK17_BIT] ? 16'(pll_k * tsa_pkg::NUM_17) : 16'(pll_k * tsa_pkg::NUM_13);
			den = clksel_q[tsa_pkg::CLK17_BIT] ? 16'(pll_p * tsa_pkg::DEN_PLL_17) : 16'(pll_p * tsa_pkg::DEN_PLL_13);
		end else begin
			num = clksel_q[tsa_pkg::CLK17_BIT] ? 16'(tsa_pkg::NUM_17) : 16'(tsa_pkg::NUM_13);
			den = clksel_q[tsa_pkg::CLK17_BIT] ? 16'(q_div * tsa_pkg::DEN_Q_17) : 16'(q_div * tsa_pkg::DEN_Q_13);
		end
	end
	assign nco_tick  = mclk_tick && (den != 16'h0000) && (acc_q + num >= den);
	assign base_tick = audio_on ? nco_tick : (osc_q == 5'(tsa_pkg::OSC_DIV - 1));
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			osc_q <= 5'h00;
			acc_q <= 16'h0000;
		end else begin
			osc_q <= (audio_on || osc_q == 5'(tsa_pkg::OSC_DIV - 1)) ? 5'h00 : osc_q + 5'h01;
			if (!audio_on && mclk_tick == 1'b0) begin
				acc_q <= acc_q;
			end
			if (audio_on && mclk_tick) begin
				acc_q <= nco_tick ? acc_q + num - den : acc_q + num;
			end
		end
	end

	logic [2:0] div_q;
	logic       conv_tick;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			div_q <= 3'h0;
		end else if (base_tick) begin
			div_q <= div_q + 3'h1;
		end
	end
	assign conv_tick = base_tick && ((div_q & ((3'h1 << adc_q[tsa_pkg::DIV_LSB +: 2]) - 3'h1)) == 3'h0);

	// Sequencer
	logic [NCH-1:0] mask;
	logic           touch, host_ctl, start, last_ch;
	logic [2:0]     next_ch;
	// Scan field sets the result set
	assign mask     = set_mask(adc_q[tsa_pkg::SCAN_LSB +: 4]);
	assign host_ctl = ctrl2_q[tsa_pkg::HOSTCTL_BIT];
	assign touch    = ~xp_level & ~hw_pd & xp_pullup_en;
	// Host start only, or also at touch
	assign start    = wr_adc_q | (~host_ctl & touch & (mask[3:0] != 4'h0));
	always_comb begin
		next_ch = ch_q;
		last_ch = 1'b1;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (i > int'(ch_q) && mask[i]) begin
				next_ch = 3'(i);
				last_ch = 1'b0;
			end
		end
	end
	logic [2:0] first_ch;
	always_comb begin
		first_ch = 3'h0;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (mask[i]) first_ch = 3'(i);
		end
	end

	logic set_done;
	assign set_done = (st_q == ST_CONV) && conv_tick && (bit_q == 4'h0) && last_ch;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_q     <= ST_IDLE;
			ch_q     <= 3'h0;
			cnt_q    <= 4'h0;
			bit_q    <= 4'h0;
			sar_code <= 12'h000;
		end else begin
			case (st_q)
				ST_IDLE: begin
					if (start && mask != '0 && !hw_pd) begin
						ch_q  <= first_ch;
						cnt_q <= 4'h0;
						st_q  <= (first_ch < 3'(tsa_pkg::CH_BAT)) ? ST_PRE : ST_SETTLE;
					end
				end
				ST_PRE: begin
					if (base_tick) cnt_q <= cnt_q + 4'h1;
					if (base_tick && cnt_q >= {1'b0, cfg_q[tsa_pkg::PRE_LSB +: 3]}) begin
						cnt_q <= 4'h0;
						st_q  <= ST_SENSE;
					end
				end
				ST_SENSE: begin
					if (base_tick) cnt_q <= cnt_q + 4'h1;
					if (base_tick && cnt_q >= {1'b0, cfg_q[tsa_pkg::SENSE_LSB +: 3]}) begin
						cnt_q <= 4'h0;
						st_q  <= xp_level ? ST_IDLE : ST_SETTLE;
					end
				end
				ST_SETTLE: begin
					if (conv_tick) cnt_q <= cnt_q + 4'h1;
					if (conv_tick && cnt_q == 4'(STAB_TICKS - 1)) begin
						// Fewer bit cycles at low resolution
						bit_q    <= res_top(adc_q[tsa_pkg::RES_LSB +: 2]);
						sar_code <= 12'h001 << res_top(adc_q[tsa_pkg::RES_LSB +: 2]);
						st_q     <= ST_CONV;
					end
				end
				ST_CONV: begin
					if (conv_tick) begin
						sar_code[bit_q] <= adc_above;
						if (bit_q != 4'h0) begin
							sar_code[bit_q - 4'h1] <= 1'b1;
							bit_q                 <= bit_q - 4'h1;
						end else begin
							ch_q  <= next_ch;
							cnt_q <= 4'h0;
							st_q  <= last_ch ? ST_IDLE : (next_ch < 3'(tsa_pkg::CH_BAT) ? ST_PRE : ST_SETTLE);
						end
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end
	assign sar_sample = (st_q == ST_SETTLE);
	assign drv_sel    = ch_q;

	// Panel bias: idle touch detect, pull-up also in ST_SENSE, precharge in ST_PRE
	assign ydrv_gnd     = (st_q == ST_IDLE) & ~hw_pd;
	assign xp_pullup_en = ((st_q == ST_IDLE) | (st_q == ST_SENSE)) & ~hw_pd;
	assign precharge_en = (st_q == ST_PRE);

	// Result store and unread tracking; completion beats a same-cycle read
	logic [NCH-1:0] rd_clr;
	assign rd_clr = (hdr_done && rd_hit) ? NCH'(1) << 3'(addr - tsa_pkg::REG_RES0) : '0;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < NCH; i++) res_q[i] <= 12'h000;
			unread_q <= '0;
		end else begin
			// Code already right-aligned: trials start at its top bit
			if (st_q == ST_CONV && conv_tick && bit_q == 4'h0) begin
				res_q[ch_q] <= {sar_code[11:1], adc_above};
			end
			unread_q <= set_done ? mask : (unread_q & ~rd_clr);
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			dav_q <= 1'b0;
		end else if (set_done) begin
			dav_q <= 1'b1;
		end else if ((unread_q & ~rd_clr) == '0) begin
			dav_q <= 1'b0;
		end
	end

	// Touch latch cleared by set done
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pen_latch_q <= 1'b0;
		end else if (touch) begin
			pen_latch_q <= 1'b1;
		end else if (set_done) begin
			pen_latch_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pen_n_q <= 1'b1;
		end else begin
			case (ctrl2_q[tsa_pkg::PMODE_LSB +: 2])
				tsa_pkg::PM_PEN: pen_n_q <= ~touch;
				tsa_pkg::PM_DAV: pen_n_q <= ~dav_q;
				default:         pen_n_q <= ~(pen_latch_q | touch);
			endcase
		end
	end
	assign link.touch_or_result_ready_n = pen_n_q;
endmodule : tsa_dev

// >>> hdl/tsa_host.sv
// Host end: serial master issuing register reads and writes
`timescale 1ns/1ps
module tsa_host #(
	parameter int HALF = 4
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	// Device link
	tsa_if.host              link,
	// User request
	input  wire logic        req,
	input  wire logic        rnw,
	input  wire logic [6:0]  addr,
	input  wire logic [15:0] wdata,
	output logic             busy,
	output logic             done,
	output logic [15:0]      rdata,
	output logic             ready_n
);
	logic [31:0] sh_q;
	logic [5:0]  bit_q;
	logic [7:0]  cnt_q;
	logic        act_q, sclk_q, done_q;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			act_q  <= 1'b0;
			sclk_q <= 1'b0;
			sh_q   <= 32'h0000_0000;
			bit_q  <= 6'h00;
			cnt_q  <= 8'h00;
			done_q <= 1'b0;
			rdata  <= 16'h0000;
		end else begin
			done_q <= 1'b0;
			if (!act_q) begin
				if (req) begin
					act_q <= 1'b1;
					sh_q  <= {rnw, 1'b0, addr, 7'h00, wdata};
					bit_q <= 6'h00;
					cnt_q <= 8'h00;
				end
			end else if (cnt_q == 8'(HALF - 1)) begin
				cnt_q  <= 8'h00;
				sclk_q <= ~sclk_q;
				if (!sclk_q) begin
					// Sample read data one cycle before the device sees this edge
					if (bit_q >= 6'(tsa_pkg::HDR_BITS)) rdata <= {rdata[14:0], link.miso_w};
				end else begin
					sh_q  <= {sh_q[30:0], 1'b0};
					bit_q <= bit_q + 6'h01;
					if (bit_q == 6'(tsa_pkg::FRAME_BITS - 1)) begin
						act_q  <= 1'b0;
						done_q <= 1'b1;
					end
				end
			end else begin
				cnt_q <= cnt_q + 8'h01;
			end
		end
	end

	// Pin taken as synchronous
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ready_n <= 1'b1;
		end else begin
			ready_n <= link.touch_or_result_ready_n;
		end
	end

	assign link.sclk = sclk_q;
	assign link.cs_n = ~act_q;
	assign link.mosi = sh_q[31];
	assign busy      = act_q;
	assign done      = done_q;
endmodule : tsa_host

// >>> verification/tsa_link_sva.sv
// Assertions on the serial link between host and converter ends
`timescale 1ns/1ps
module tsa_link_sva #(
	parameter int HALF = 4
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// Serial link
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic miso_o,
	input wire logic miso_oe
);
	logic       sclk_q;
	logic       rd_q;
	logic [5:0] rise_q;
	logic [7:0] hi_q;
	// Frame bookkeeping, cleared between frames
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sclk_q <= 1'b0;
			rise_q <= 6'h00;
			rd_q   <= 1'b0;
		end else begin
			sclk_q <= sclk;
			rise_q <= cs_n ? 6'h00 : rise_q + {5'h00, sclk & ~sclk_q};
			if (cs_n)
				rd_q <= 1'b0;
			else if (sclk && !sclk_q && rise_q == 6'h00)
				rd_q <= mosi;
		end
	end
	// Length of each high phase
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			hi_q <= 8'h00;
		else
			hi_q <= sclk ? hi_q + 8'h01 : 8'h00;
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	sequence s_low;
		!sclk [*4];
	endsequence
	sequence s_hdr;
		rd_q && rise_q >= 6'd16;
	endsequence
	property p_idle; cs_n |-> !sclk; endproperty
	property p_high; $fell(sclk) |-> hi_q == 8'(HALF); endproperty
	property p_low; $fell(sclk) && !cs_n |-> s_low; endproperty
	property p_len; $rose(cs_n) |-> rise_q == 6'd32; endproperty
	property p_mosi; !cs_n && $changed(mosi) |-> $fell(sclk) || $fell(cs_n); endproperty
	property p_oe; miso_oe |-> !cs_n ##0 s_hdr; endproperty
	property p_oe_start; $rose(miso_oe) |-> rise_q == 6'd16; endproperty
	property p_miso; miso_oe && $past(miso_oe) && $changed(miso_o) |-> $past(sclk); endproperty
	a_idle: assert property (p_idle)
		else $error("serial clock runs outside a frame");
	a_high: assert property (p_high)
		else $error("serial clock high phase has wrong length");
	a_low: assert property (p_low)
		else $error("serial clock low phase too short");
	a_len: assert property (p_len)
		else $error("frame does not hold 32 clock rises");
	a_mosi: assert property (p_mosi)
		else $error("host data changed away from a falling clock");
	a_oe: assert property (p_oe)
		else $error("device drives data outside a read data phase");
	a_oe_start: assert property (p_oe_start)
		else $error("read data starts at the wrong bit");
	a_miso: assert property (p_miso)
		else $error("read data changed while clock low");
endmodule : tsa_link_sva

// >>> verification/touch_adc_clock_and_pen_irq_tb.sv
// Self-checking bench for the host and converter ends
`timescale 1ns/1ps
module touch_adc_clock_and_pen_irq_tb;
	typedef struct packed {logic [6:0] a; logic [15:0] w, m, e, r;} tsa_row_t;
	logic        ref_clk = 1'b0;
	logic        nrst = 1'b0;
	logic        xp_level = 1'b1;
	logic        hw_pd = 1'b0;
	logic        adc_above = 1'b1;
	logic        audio_on = 1'b0;
	logic        mclk_tick = 1'b0;
	logic        pll_en = 1'b0;
	logic [5:0]  pll_k = 6'h01;
	logic [2:0]  pll_p = 3'h1;
	logic [3:0]  q_div = 4'h4;
	logic        req = 1'b0;
	logic        rnw = 1'b0;
	logic [6:0]  addr = 7'h00;
	logic [15:0] wdata = 16'h0000;
	logic        done, ready_n, ydrv_gnd, xp_pullup_en, precharge_en, sar_sample, ratiometric;
	logic        int_ref_on, ref_2v5, osc_pd;
	logic        saw_rat = 1'b0, saw_pre = 1'b0, bad_pu = 1'b0;
	logic [15:0] rdata, rd;
	int          num_errors = 0, n_tests = 0, cyc = 0;
	int          t [4];
	logic [6:0]  ra [5] = '{tsa_pkg::REG_ADC, tsa_pkg::REG_CTRL2, tsa_pkg::REG_REF, tsa_pkg::REG_CFG,
		tsa_pkg::REG_CLKSEL};
	logic [15:0] rv [5] = '{tsa_pkg::RST_ADC, tsa_pkg::RST_CTRL2, tsa_pkg::RST_REF, tsa_pkg::RST_CFG,
		tsa_pkg::RST_CLKSEL};
	// Address, write, readback mask, readback, reference pins
	// Last row leaves internal reference off for panel scans
	tsa_row_t    rows [6] = '{
		'{tsa_pkg::REG_REF, 16'h0001, 16'h0003, 16'h0001, 16'h0003},
		'{tsa_pkg::REG_REF, 16'h0002, 16'h0003, 16'h0002, 16'h0000},
		'{tsa_pkg::REG_CFG, 16'h003f, 16'h003f, 16'h003f, 16'h0000},
		'{tsa_pkg::REG_CLKSEL, 16'h2000, 16'h2000, 16'h2000, 16'h0000},
		'{7'h7f, 16'hffff, 16'hffff, 16'h0000, 16'h0000},
		'{tsa_pkg::REG_REF, 16'h0003, 16'h0003, 16'h0003, 16'h0001}};
	// Each resolution only with its allowed clock
	logic [1:0]  cr [4] = '{tsa_pkg::RES_8, tsa_pkg::RES_10, tsa_pkg::RES_12, tsa_pkg::RES_12};
	logic [1:0]  cd [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
	int          cb [4] = '{8, 10, 12, 12};

	always #2.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) mclk_tick <= audio_on & ~mclk_tick;
	always @(posedge ref_clk) begin
		if (sar_sample && ratiometric) saw_rat <= 1'b1;
		if (precharge_en) saw_pre <= 1'b1;
		if (sar_sample && xp_pullup_en) bad_pu <= 1'b1;
	end
	// Whole run needs about 19k cycles
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 60000) begin
			num_errors++;
			stop_test();
		end
	end

	tsa_if u_tsa_if ();
	tsa_dev #(.STAB_TICKS(4)) u_tsa_dev (.ref_clk(ref_clk), .nrst(nrst), .link(u_tsa_if.dev),
		.xp_level(xp_level), .hw_pd(hw_pd), .adc_above(adc_above), .ydrv_gnd(ydrv_gnd),
		.xp_pullup_en(xp_pullup_en), .precharge_en(precharge_en), .drv_sel(), .sar_sample(sar_sample),
		.sar_code(), .ratiometric(ratiometric), .int_ref_on(int_ref_on), .ref_2v5(ref_2v5),
		.audio_on(audio_on), .mclk_tick(mclk_tick), .pll_en(pll_en), .pll_k(pll_k), .pll_p(pll_p),
		.q_div(q_div), .osc_pd(osc_pd));
	tsa_host #(.HALF(4)) u_tsa_host (.ref_clk(ref_clk), .nrst(nrst), .link(u_tsa_if.host), .req(req),
		.rnw(rnw), .addr(addr), .wdata(wdata), .busy(), .done(done), .rdata(rdata), .ready_n(ready_n));
	tsa_link_sva #(.HALF(4)) u_tsa_link_sva (.ref_clk(ref_clk), .nrst(nrst), .sclk(u_tsa_if.sclk),
		.cs_n(u_tsa_if.cs_n), .mosi(u_tsa_if.mosi), .miso_o(u_tsa_if.miso_o), .miso_oe(u_tsa_if.miso_oe));

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	function automatic logic [15:0] inr(input int v, input int lo, input int hi);
		return (v >= lo && v <= hi) ? 16'h0001 : 16'h0000;
	endfunction : inr

	task automatic xfer(input logic r, input logic [6:0] a, input logic [15:0] w);
		int n;
		n = 0;
		@(posedge ref_clk);
		req   <= 1'b1;
		rnw   <= r;
		addr  <= a;
		wdata <= w;
		@(posedge ref_clk);
		req <= 1'b0;
		while (done !== 1'b1 && n < 1000) begin
			@(posedge ref_clk);
			n++;
		end
		if (n == 1000) num_errors++;
		rd = rdata;
		#1;
	endtask : xfer

	task automatic wait_pin(input logic lv, output int n);
		n = 0;
		while (ready_n !== lv && n < 4000) begin
			@(posedge ref_clk);
			n++;
		end
		if (n == 4000) num_errors++;
	endtask : wait_pin

	// Pin and host copy a few cycles after a panel change
	task automatic pen(input logic xp, input logic pd, input logic [15:0] exp);
		@(posedge ref_clk);
		xp_level <= xp;
		hw_pd    <= pd;
		repeat (4) @(posedge ref_clk);
		#1;
		chk("pin", {14'h0, u_tsa_if.touch_or_result_ready_n, ready_n}, exp);
	endtask : pen

	task automatic conv(input logic [1:0] res, input logic [1:0] dv, input int bits, output int n);
		xfer(1'b0, tsa_pkg::REG_ADC, {2'h0, tsa_pkg::SCAN_BAT, res, 2'h0, dv, 4'h0});
		wait_pin(1'b0, n);
		repeat (40) @(posedge ref_clk);
		#1;
		chk("dav_hold", {15'h0, ready_n}, 16'h0000);
		xfer(1'b1, tsa_pkg::REG_RES0 + 7'(tsa_pkg::CH_BAT), 16'h0000);
		chk("result", rd, 16'((1 << bits) - 1));
		repeat (3) @(posedge ref_clk);
		#1;
		chk("dav_clr", {15'h0, ready_n}, 16'h0001);
	endtask : conv

	task automatic stop_test;
		if (num_errors == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : stop_test

	initial begin
		int n;
		repeat (4) @(posedge ref_clk);
		#1;
		chk("rst", {12'h0, u_tsa_if.cs_n, u_tsa_if.sclk, u_tsa_if.miso_oe, ready_n}, 16'h0009);
		@(posedge ref_clk);
		nrst <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			xfer(1'b1, ra[i], 16'h0000);
			chk("rst_reg", rd, rv[i]);
		end
		chk("ref_rst", {14'h0, int_ref_on, ref_2v5}, 16'h0002);
		for (int i = 0; i < 6; i++) begin
			xfer(1'b0, rows[i].a, rows[i].w);
			xfer(1'b1, rows[i].a, 16'h0000);
			chk("rdbk", rd & rows[i].m, rows[i].e);
			chk("ref", {14'h0, int_ref_on, ref_2v5}, rows[i].r);
		end
		xfer(1'b0, tsa_pkg::REG_CTRL2, 16'h1000);
		chk("idle", {14'h0, ydrv_gnd, xp_pullup_en}, 16'h0003);
		pen(1'b0, 1'b0, 16'h0000);
		pen(1'b1, 1'b0, 16'h0003);
		pen(1'b0, 1'b1, 16'h0003);
		chk("pd_drv", {15'h0, ydrv_gnd}, 16'h0000);
		pen(1'b0, 1'b0, 16'h0000);
		xfer(1'b0, tsa_pkg::REG_CTRL2, 16'h5000);
		xfer(1'b0, tsa_pkg::REG_ADC, {2'h0, tsa_pkg::SCAN_XY, tsa_pkg::RES_8, 8'h00});
		wait_pin(1'b0, n);
		xfer(1'b1, tsa_pkg::REG_RES0, 16'h0000);
		chk("x", rd, 16'h00ff);
		chk("dav_x", {15'h0, ready_n}, 16'h0000);
		xfer(1'b1, tsa_pkg::REG_RES0 + 7'h01, 16'h0000);
		repeat (3) @(posedge ref_clk);
		#1;
		chk("dav_xy", {15'h0, ready_n}, 16'h0001);
		chk("panel", {13'h0, saw_rat, saw_pre, bad_pu}, 16'h0006);
		@(posedge ref_clk);
		xp_level <= 1'b1;
		for (int i = 0; i < 4; i++) conv(cr[i], cd[i], cb[i], t[i]);
		// Four settle ticks plus one per bit, any phase
		chk("t_8", inr(t[0], 270, 320), 16'h0001);
		chk("t_10", inr(t[1], 640, 720), 16'h0001);
		chk("t_12", inr(t[2], 1490, 1620), 16'h0001);
		chk("t_div", inr(t[3], 2990, 3220), 16'h0001);
		@(posedge ref_clk);
		audio_on <= 1'b1;
		conv(tsa_pkg::RES_8, 2'h0, 8, n);
		chk("osc_pd", {15'h0, osc_pd}, 16'h0001);
		chk("t_mclk", inr(n, 0, t[0] / 2), 16'h0001);
		@(posedge ref_clk);
		audio_on <= 1'b0;
		xfer(1'b0, tsa_pkg::REG_CTRL2, 16'h9000);
		chk("osc_on", {15'h0, osc_pd}, 16'h0000);
		xfer(1'b0, tsa_pkg::REG_ADC, {2'h0, tsa_pkg::SCAN_X, tsa_pkg::RES_8, 8'h00});
		// Written start aborts at sense: panel untouched
		repeat (500) @(posedge ref_clk);
		pen(1'b0, 1'b0, 16'h0000);
		repeat (800) @(posedge ref_clk);
		// Host control: lifting the pen alone must not end the low phase
		pen(1'b1, 1'b0, 16'h0000);
		xfer(1'b0, tsa_pkg::REG_CTRL2, 16'h8000);
		@(posedge ref_clk);
		xp_level <= 1'b0;
		// Lift the pen after sensing, before the set completes
		repeat (450) @(posedge ref_clk);
		xp_level <= 1'b1;
		wait_pin(1'b1, n);
		xfer(1'b1, tsa_pkg::REG_RES0, 16'h0000);
		chk("self_x", rd, 16'h00ff);
		stop_test();
	end
endmodule : touch_adc_clock_and_pen_irq_tb
